/* pkg/cmb_map.svh */
// Register offsets, field positions and reset values of the message
// buffer and filter block. Included by the package users by bare name.
// Overview of operation
// [R1] Received frames queue in two stages; only foreground is host-visible.
// [R2] Each receive stage holds thirteen bytes: control, identifier and data.
// [R3] Receive-full is set only for an error-free frame passing the filter.
// [R4] Every frame writes the background stage while filtering runs alongside; here bg_q is held while bg_pend_q is set.
// [R5] Accepted frame goes to foreground if flag clear; flag, interrupt set.
// [R6] Host reads the foreground, then clears receive-full to free it.
// [R7] Own sent frames stay in background: no flag, no interrupt, no ack.
// [R8] In loop-back mode own frames are handled like any received frame.
// [R9] After lost arbitration the node receives the winning frame normally.
// [R10] Accepted frame with both stages full is discarded and overrun raised.
// [R11] Three transmit buffers of thirteen bytes, each with 8-bit priority.
// [R12] Host loads an empty buffer, then clears its empty flag to send.
// [R13] Successful send sets the buffer's empty flag and transmit interrupt.
// [R14] Among ready buffers the smallest priority value is sent first.
// [R15] Buffer selection reruns at every arbitration, retries included.
// [R16] Abort request on a buffer not on bus sets acknowledge and empty.
// [R17] Four code bytes give the pattern; mask bits exclude bits from compare.
// [R18] A 2-bit hit field reports the lowest-numbered matching filter.
// [R19] Single mode compares all 32 extended or 13 standard identifier bits.
// [R20] Dual mode: two filters on upper extended bits or standard identifier.
// [R21] Quad mode: four filters each on the first eight identifier bits.
// [R22] Closed mode never copies to foreground nor sets receive-full.
// [R23] Flags clear only by writing one, and the set wins over clear; here aack_q is also cleared by a successful send.
// [R24] A software-written field selects single, dual, quad or closed mode.
`ifndef CMB_MAP_SVH
`define CMB_MAP_SVH
`define CMB_CTRL 8'h00
`define CMB_RXFLG 8'h04
`define CMB_RXIE 8'h08
`define CMB_TXFLG 8'h0C
`define CMB_TXCTL 8'h10
`define CMB_ACODE 8'h14
`define CMB_AMASK 8'h18
`define CMB_HIT 8'h1C
`define CMB_RX_FOREGROUND_STAGE_NIB 4'h4
`define CMB_LOCAL_PRIORITY_WORD 3'h4
`define CMB_NBYTE 13
`define CMB_NBUF 3
`define CMB_IDE_BIT 3
`define CMB_STD_CARE 8'hF8
`define CMB_ALL_CARE 8'hFF
`define CMB_TXE_RST 3'h7
`endif

/* pkg/cmb_pkg.sv */
// Types shared by the message buffer and filter block.
// Assumes the frame engine delivers bytes and events one cycle each.
package cmb_pkg;
  typedef enum logic [1:0] {FM_SINGLE, FM_DUAL, FM_QUAD, FM_CLOSED} cmb_fmode_e;
  typedef struct packed {
    logic valid;
    logic [3:0] idx;
    logic [7:0] data;
    logic done_ok;
  } cmb_rx_s;
  typedef struct packed {
    logic arb;
    logic done_ok;
    logic lost;
    logic error;
  } cmb_txev_s;
endpackage : cmb_pkg

/* design/cmb_top.sv */
// Message storage, transmit scheduling and acceptance filtering.
// Assumes a frame engine on ref_clk and a single-master AHB-Lite bus.
//
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "cmb_map.svh"
module cmb_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire cmb_pkg::cmb_rx_s rx_in,
  input wire cmb_pkg::cmb_txev_s tx_ev,
  input wire logic [3:0] tx_byte_idx,
  output logic [7:0] tx_byte,
  output logic [1:0] tx_sel,
  output logic tx_sel_valid,
  output logic ack_enable,
  output logic rx_irq,
  output logic tx_irq,
  output logic err_irq
);
  localparam int NB = `CMB_NBYTE;
  localparam int NT = `CMB_NBUF;

  logic [7:0] bg_q [NB];
  logic [7:0] fg_q [NB];
  logic [7:0] id_q [4];
  logic [7:0] tx_q [NT][NB];
  logic [7:0] local_priority_q [NT];
  logic loop_q;
  cmb_pkg::cmb_fmode_e mode_q;
  logic [1:0] rxie_q;
  logic [2:0] txie_q;
  logic [31:0] code_q;
  logic [31:0] mask_q;
  logic rx_full_q;
  logic ovr_q;
  logic bg_pend_q;
  logic [1:0] bg_hit_q;
  logic [1:0] fg_hit_q;
  logic [2:0] empty_q;
  logic [2:0] aack_q;
  logic [2:0] abort_q;
  logic tx_active_q;
  logic [1:0] tx_sel_q;
  logic [7:0] tx_byte_q;
  logic wen_q;
  logic [7:0] addr_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_v;
  logic ap;
  logic map_ok;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign ap = hsel && htrans[1] && hready;
  assign map_ok = (haddr[31:8] == 24'h00_0000);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wen_q <= 1'b0;
      addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end
    else
    begin
      wen_q <= ap && hwrite && map_ok;
      addr_q <= haddr[7:0];
      hrdata_q <= (ap && !hwrite && map_ok) ? rd_v : 32'h0000_0000;
    end
  end

  logic wr_ctrl, wr_rxflg, wr_rxie, wr_txflg, wr_txctl, wr_code, wr_mask;
  logic wr_tx;
  logic [1:0] wb;
  assign wr_ctrl = wen_q && (addr_q == `CMB_CTRL);
  assign wr_rxflg = wen_q && (addr_q == `CMB_RXFLG);
  assign wr_rxie = wen_q && (addr_q == `CMB_RXIE);
  assign wr_txflg = wen_q && (addr_q == `CMB_TXFLG);
  assign wr_txctl = wen_q && (addr_q == `CMB_TXCTL);
  assign wr_code = wen_q && (addr_q == `CMB_ACODE);
  assign wr_mask = wen_q && (addr_q == `CMB_AMASK);
  assign wb = addr_q[6:5];
  assign wr_tx = wen_q && addr_q[7] && (wb != 2'b11);

  // Read mux; buffer words pack four bytes, first byte lowest
  always_comb
  begin
    logic [1:0] b;
    logic [3:0] bi;
    rd_v = 32'h0000_0000;
    b = haddr[6:5];
    bi = 4'h0;
    case (haddr[7:0])
      `CMB_CTRL: rd_v = {29'h0000_0000, mode_q, loop_q};
      `CMB_RXFLG: rd_v = {30'h0000_0000, ovr_q, rx_full_q};
      `CMB_RXIE: rd_v = {30'h0000_0000, rxie_q};
      `CMB_TXFLG: rd_v = {25'h000_0000, aack_q, 1'b0, empty_q};
      `CMB_TXCTL: rd_v = {25'h000_0000, txie_q, 1'b0, abort_q};
      `CMB_ACODE: rd_v = code_q;
      `CMB_AMASK: rd_v = mask_q;
      `CMB_HIT: rd_v = {30'h0000_0000, fg_hit_q};
      default:
      begin
        for (int k = 0; k < 4; k++)
        begin
          bi = {haddr[3:2], 2'b00} + 4'(k);
          if (haddr[7:4] == `CMB_RX_FOREGROUND_STAGE_NIB && int'(bi) < NB)
            rd_v[8*k +: 8] = fg_q[bi]; // R1
          else if (haddr[7] && b != 2'b11 && !haddr[4] && int'(bi) < NB)
            rd_v[8*k +: 8] = tx_q[b][bi];
        end
        if (haddr[7] && b != 2'b11 && haddr[4:2] == `CMB_LOCAL_PRIORITY_WORD)
          rd_v = {24'h00_0000, local_priority_q[b]};
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      loop_q <= 1'b0;
      mode_q <= cmb_pkg::FM_SINGLE;
      rxie_q <= 2'h0;
      txie_q <= 3'h0;
      code_q <= 32'h0000_0000;
      mask_q <= 32'h0000_0000;
    end
    else
    begin
      if (wr_ctrl)
      begin
        loop_q <= hwdata[0];
        mode_q <= cmb_pkg::cmb_fmode_e'(hwdata[2:1]); // R24
      end
      if (wr_rxie)
        rxie_q <= hwdata[1:0];
      if (wr_txctl)
        txie_q <= hwdata[6:4];
      if (wr_code)
        code_q <= hwdata; // R17
      if (wr_mask)
        mask_q <= hwdata; // R17
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acceptance filter on the incoming identifier bytes
  function automatic logic fm(input logic [7:0] id, input logic [7:0] c,
                              input logic [7:0] m, input logic [7:0] care);
    fm = (((id ^ c) & ~m & care) == 8'h00); // R17
  endfunction : fm

  logic [3:0] hits;
  logic [1:0] hit_num;
  logic hit_any;
  logic ext;
  logic [7:0] care1;
  assign ext = id_q[1][`CMB_IDE_BIT];
  assign care1 = ext ? `CMB_ALL_CARE : `CMB_STD_CARE;

  // Identifier of the frame on the wire, taken even while background is held
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      id_q <= '{default: 8'h00};
    else if (rx_in.valid && rx_in.idx < 4'h4)
      id_q[rx_in.idx[1:0]] <= rx_in.data; // R4
  end

  always_comb
  begin
    hits = 4'h0;
    case (mode_q) // R24
      cmb_pkg::FM_SINGLE:
        hits[0] = fm(id_q[0], code_q[7:0], mask_q[7:0], `CMB_ALL_CARE)
          && fm(id_q[1], code_q[15:8], mask_q[15:8], care1)
          && (!ext
          || (fm(id_q[2], code_q[23:16], mask_q[23:16], `CMB_ALL_CARE)
          && fm(id_q[3], code_q[31:24], mask_q[31:24], `CMB_ALL_CARE))); // R19
      cmb_pkg::FM_DUAL:
      begin
        hits[0] = fm(id_q[0], code_q[7:0], mask_q[7:0], `CMB_ALL_CARE)
          && fm(id_q[1], code_q[15:8], mask_q[15:8], care1); // R20
        hits[1] = fm(id_q[0], code_q[23:16], mask_q[23:16], `CMB_ALL_CARE)
          && fm(id_q[1], code_q[31:24], mask_q[31:24], care1); // R20
      end
      cmb_pkg::FM_QUAD:
        for (int k = 0; k < 4; k++)
          hits[k] = fm(id_q[0], code_q[8*k +: 8], mask_q[8*k +: 8],
                       `CMB_ALL_CARE); // R21
      default: hits = 4'h0; // R22
    endcase
  end

  // Lowest-numbered filter wins
  assign hit_any = |hits;
  assign hit_num = hits[0] ? 2'd0 : hits[1] ? 2'd1
    : hits[2] ? 2'd2 : 2'd3; // R18

  ////////////////////////////////////////////////////////////////////////////
  // Receive queue
  logic own;
  logic accept;
  logic copy;
  assign own = tx_active_q && !loop_q; // R7 R8 R9
  assign accept = rx_in.done_ok && hit_any && !own; // R3
  assign copy = bg_pend_q && !rx_full_q; // R5
  assign ack_enable = !own; // R7

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NB; i++)
      begin
        bg_q[i] <= 8'h00;
        fg_q[i] <= 8'h00;
      end
    end
    else
    begin
      // Held while an accepted frame still waits for the foreground
      if (rx_in.valid && !bg_pend_q && int'(rx_in.idx) < NB)
        bg_q[rx_in.idx] <= rx_in.data; // R2 R4
      if (copy)
        for (int i = 0; i < NB; i++)
          fg_q[i] <= bg_q[i]; // R1 R5
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bg_pend_q <= 1'b0;
      bg_hit_q <= 2'h0;
      fg_hit_q <= 2'h0;
      rx_full_q <= 1'b0;
      ovr_q <= 1'b0;
    end
    else
    begin
      if (accept && !bg_pend_q)
      begin
        bg_pend_q <= 1'b1;
        bg_hit_q <= hit_num; // R18
      end
      else if (copy)
        bg_pend_q <= 1'b0;
      if (copy)
      begin
        rx_full_q <= 1'b1; // R5
        fg_hit_q <= bg_hit_q;
      end
      else if (wr_rxflg && hwdata[0])
        rx_full_q <= 1'b0; // R6 R23
      if (accept && bg_pend_q)
        ovr_q <= 1'b1; // R10
      else if (wr_rxflg && hwdata[1])
        ovr_q <= 1'b0; // R23
    end
  end

  assign rx_irq = rx_full_q && rxie_q[0]; // R5
  assign err_irq = ovr_q && rxie_q[1]; // R10

  ////////////////////////////////////////////////////////////////////////////
  // Transmit buffers and scheduling
  logic [2:0] grant;
  logic [2:0] sent;
  logic found;
  logic [1:0] best;
  logic [7:0] bestp;

  genvar g;
  generate
    for (g = 0; g < NT; g++)
    begin : g_buf
      assign sent[g] = tx_ev.done_ok && tx_active_q && (tx_sel_q == 2'(g));
      assign grant[g] = abort_q[g] && !empty_q[g]
        && !(tx_active_q && tx_sel_q == 2'(g)); // R16
    end
  endgenerate

  always_comb
  begin
    found = 1'b0;
    best = 2'd0;
    bestp = 8'hFF;
    for (int i = 0; i < NT; i++)
      if (!empty_q[i] && !abort_q[i] && (!found || local_priority_q[i] < bestp))
      begin
        found = 1'b1;
        best = 2'(i);
        bestp = local_priority_q[i]; // R14
      end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int b = 0; b < NT; b++)
      begin
        local_priority_q[b] <= 8'h00;
        for (int i = 0; i < NB; i++)
          tx_q[b][i] <= 8'h00;
      end
    end
    else if (wr_tx)
    begin
      if (addr_q[4:2] == `CMB_LOCAL_PRIORITY_WORD)
        local_priority_q[wb] <= hwdata[7:0]; // R11
      else if (!addr_q[4])
        for (int k = 0; k < 4; k++)
          if ((4 * int'(addr_q[3:2]) + k) < NB)
            tx_q[wb][4'({addr_q[3:2], 2'b00}) + 4'(k)] <= hwdata[8*k +: 8]; // R11
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      empty_q <= `CMB_TXE_RST;
      aack_q <= 3'h0;
      abort_q <= 3'h0;
    end
    else
    begin
      for (int i = 0; i < NT; i++)
      begin
        if (sent[i] || grant[i])
          empty_q[i] <= 1'b1; // R13 R16
        else if (wr_txflg && hwdata[i])
          empty_q[i] <= 1'b0; // R12 R23
        if (grant[i])
          aack_q[i] <= 1'b1; // R16
        else if (sent[i] || (wr_txflg && hwdata[i]))
          aack_q[i] <= 1'b0; // R16
        if (sent[i] || grant[i])
          abort_q[i] <= 1'b0;
        else if (wr_txctl && hwdata[i] && !empty_q[i])
          abort_q[i] <= 1'b1; // R16
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_active_q <= 1'b0;
      tx_sel_q <= 2'd0;
    end
    else if (tx_ev.arb)
    begin
      tx_active_q <= found; // R15
      tx_sel_q <= best; // R14
    end
    else if (tx_ev.done_ok || tx_ev.lost || tx_ev.error)
      tx_active_q <= 1'b0; // R9 R15
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      tx_byte_q <= 8'h00;
    else if (int'(tx_byte_idx) < NB)
      tx_byte_q <= tx_q[tx_sel_q][tx_byte_idx];
    else
      tx_byte_q <= 8'h00;
  end

  assign tx_byte = tx_byte_q;
  assign tx_sel = tx_sel_q;
  assign tx_sel_valid = tx_active_q;
  assign tx_irq = |(empty_q & txie_q); // R13

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_accept_free;
    accept && !bg_pend_q && !rx_full_q;
  endsequence

  sequence s_copy_done;
    bg_pend_q ##1 rx_full_q && !bg_pend_q;
  endsequence

  rxf_cause_a: assert property ($rose(rx_full_q) |-> $past(bg_pend_q)) // R3
    else $error("receive-full set without pending frame");
  accept_copy_a: assert property (s_accept_free |=> s_copy_done) // R5
    else $error("accepted frame not copied in two cycles");
  fg_hold_a: assert property (rx_full_q |=> $stable(fg_q[0])) // R5
    else $error("foreground changed while full");
  closed_mode_a: assert property ((mode_q == cmb_pkg::FM_CLOSED) && rx_in.done_ok
      && !bg_pend_q |=> !bg_pend_q) // R22
    else $error("closed filter accepted a frame");
  own_frame_a: assert property (rx_in.done_ok && tx_active_q && !loop_q
      && !bg_pend_q |-> ack_enable == 1'b0 ##1 !bg_pend_q) // R7
    else $error("own frame accepted or acknowledged");
  loop_own_a: assert property (rx_in.done_ok && hit_any && loop_q && !bg_pend_q
      |=> bg_pend_q) // R8
    else $error("loop-back frame not accepted");
  overrun_a: assert property (accept && bg_pend_q && !(wr_rxflg && hwdata[1])
      |=> ovr_q ##1 ovr_q || $past(wr_rxflg)) // R10
    else $error("overrun not flagged");
  txe_done_a: assert property (tx_ev.done_ok && tx_active_q
      |=> empty_q[$past(tx_sel_q)] && !aack_q[$past(tx_sel_q)]) // R13
    else $error("sent buffer not released");
  local_priority_sel_a: assert property (tx_ev.arb && found |=> tx_sel_valid
      && (empty_q[0] || local_priority_q[0] >= local_priority_q[tx_sel_q])
      && (empty_q[1] || local_priority_q[1] >= local_priority_q[tx_sel_q])
      && (empty_q[2] || local_priority_q[2] >= local_priority_q[tx_sel_q])) // R14
    else $error("lower priority buffer chosen");
  abort_ack_a: assert property (grant[0] |=> empty_q[0] && aack_q[0]
      && !abort_q[0]) // R16
    else $error("abort not acknowledged");
  hit_low_a: assert property ((mode_q == cmb_pkg::FM_QUAD) && accept
      && !bg_pend_q && hits[0] |=> bg_hit_q == 2'd0) // R18
    else $error("hit field not lowest filter");
endmodule : cmb_top
`default_nettype wire

/* testbench/cmb_bus_model.sv */
// Behavioural frame engine on the bus side of the message buffer block.
// Assumes one ref_clk domain; all events are single-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module cmb_bus_model (
  input wire logic ref_clk,
  output cmb_pkg::cmb_rx_s rx_in,
  output cmb_pkg::cmb_txev_s tx_ev,
  output logic [3:0] tx_byte_idx
);
  initial
  begin
    rx_in = '0;
    tx_ev = '0;
    tx_byte_idx = 4'h0;
  end
  // Thirteen bytes, then the end-of-frame pulse a cycle later
  task automatic frame(input logic [103:0] f, input logic ok);
    for (int i = 0; i < 13; i++)
    begin
      @(posedge ref_clk);
      rx_in <= {1'b1, 4'(i), f[8*i+:8], 1'b0};
    end
    @(posedge ref_clk);
    rx_in <= {1'b0, 4'hF, ~f[103:96], ok};
    @(posedge ref_clk);
    rx_in <= {1'b0, 4'hF, f[103:96], 1'b0};
    repeat (4) @(posedge ref_clk);
  endtask : frame
  // Bits: arb, done_ok, lost, error
  task automatic ev(input logic [3:0] e);
    @(posedge ref_clk);
    tx_ev <= e;
    @(posedge ref_clk);
    tx_ev <= 4'h0;
    repeat (2) @(posedge ref_clk);
  endtask : ev
  task automatic fetch(input logic [3:0] i);
    @(posedge ref_clk);
    tx_byte_idx <= i;
    repeat (2) @(posedge ref_clk);
  endtask : fetch
endmodule : cmb_bus_model
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for the message buffer and filter block.
// Assumes the frame engine model and a single AHB-Lite master here.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0;
  logic rst_n;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  cmb_pkg::cmb_rx_s rx_in;
  cmb_pkg::cmb_txev_s tx_ev;
  logic [3:0] tx_byte_idx;
  logic [7:0] tx_byte;
  logic [1:0] tx_sel;
  logic tx_sel_valid;
  logic ack_enable;
  logic rx_irq;
  logic tx_irq;
  logic err_irq;
  int n_errors = 0;
  int tests_run = 0;
  int seed = 4131;
  logic rd_pend = 1'b0;
  logic [31:0] exp_q [$];
  logic [103:0] fr;
  logic [103:0] f3;
  logic [31:0] dw [3];
  logic [7:0] p [3];
  logic [2:0] rdy;
  logic [1:0] s;
  always #2.5 ref_clk = ~ref_clk;
  cmb_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .rx_in(rx_in), .tx_ev(tx_ev),
    .tx_byte_idx(tx_byte_idx), .tx_byte(tx_byte), .tx_sel(tx_sel),
    .tx_sel_valid(tx_sel_valid), .ack_enable(ack_enable),
    .rx_irq(rx_irq), .tx_irq(tx_irq), .err_irq(err_irq));
  cmb_bus_model bus (.ref_clk(ref_clk), .rx_in(rx_in), .tx_ev(tx_ev),
    .tx_byte_idx(tx_byte_idx));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    if (n_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  // Read results come back through the queue in bus order
  always @(posedge ref_clk) rd_pend <= hsel && htrans[1] && !hwrite && hreadyout;
  always @(negedge ref_clk) if (rd_pend && exp_q.size() > 0) chk(hrdata, exp_q.pop_front());
  ////////////////////////////////////////////////////////////////////////
  task automatic bus_cyc(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge ref_clk); while (!hreadyout);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (!hreadyout);
  endtask : bus_cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_cyc(a, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus_cyc(a, 1'b0, 32'h0);
  endtask : rd
  // Standard frame: identifier byte1 0x20 keeps the extension bit clear
  task automatic rx_fr(input logic [7:0] b0, input logic ok);
    fr = {$random(seed), $random(seed), $random(seed), 8'h00};
    fr[15:0] = {8'h20, b0};
    bus.frame(fr, ok);
  endtask : rx_fr
  function automatic logic [1:0] pick(input logic [2:0] r);
    logic [1:0] b;
    logic [8:0] best;
    b = 2'd3;
    best = 9'h100;
    for (int i = 0; i < 3; i++)
      if (r[i] && {1'b0, p[i]} < best)
      begin
        best = {1'b0, p[i]};
        b = 2'(i);
      end
    return b;
  endfunction : pick
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    summarize();
  end
  initial
  begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = $random(seed);
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = $random(seed);
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h0C, 32'h7);
    rd(8'h04, 32'h0);
    wr(8'h3C, 32'hFFFF_FFFF);
    rd(8'h3C, 32'h0);
    wr(8'h08, 32'h3);
    wr(8'h14, 32'h0000_205A);
    wr(8'h18, 32'h0);
    rx_fr(8'h5A, 1'b0);
    rd(8'h04, 32'h0);
    rx_fr(8'h5A, 1'b1);
    rd(8'h04, 32'h1);
    rd(8'h40, fr[31:0]);
    rd(8'h48, fr[95:64]);
    rd(8'h4C, {24'h00_0000, fr[103:96]});
    rd(8'h1C, 32'h0);
    @(negedge ref_clk);
    chk({31'h0, rx_irq}, 32'h1);
    wr(8'h04, 32'h1);
    rx_fr(8'h5B, 1'b1);
    rd(8'h04, 32'h0);
    rx_fr(8'h5A, 1'b1);
    rx_fr(8'h5A, 1'b1);
    f3 = fr;
    rx_fr(8'h77, 1'b1);
    rd(8'h04, 32'h1);
    wr(8'h18, 32'h0000_00FF);
    rx_fr(8'h77, 1'b1);
    wr(8'h18, 32'h0);
    rd(8'h04, 32'h3);
    @(negedge ref_clk);
    chk({31'h0, err_irq}, 32'h1);
    wr(8'h04, 32'h1);
    rd(8'h04, 32'h3);
    rd(8'h40, f3[31:0]);
    rd(8'h44, f3[63:32]);
    wr(8'h04, 32'h3);
    rd(8'h04, 32'h0);
    wr(8'h00, 32'h6);
    rx_fr(8'h5A, 1'b1);
    rd(8'h04, 32'h0);
    wr(8'h00, 32'h2);
    wr(8'h14, 32'h205A_0000);
    rx_fr(8'h5A, 1'b1);
    rd(8'h1C, 32'h1);
    wr(8'h04, 32'h1);
    wr(8'h00, 32'h4);
    rd(8'h00, 32'h4);
    wr(8'h14, 32'h5A5A_1122);
    rx_fr(8'h5A, 1'b1);
    rd(8'h1C, 32'h2);
    wr(8'h04, 32'h1);
    wr(8'h14, 32'h0000_205A);
    wr(8'h00, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      p[i] = 8'($random(seed));
      dw[i] = $random(seed);
      wr(8'h90 + 8'(32*i), {24'h00_0000, p[i]});
      wr(8'h80 + 8'(32*i), dw[i]);
      rd(8'h80 + 8'(32*i), dw[i]);
    end
    wr(8'h0C, 32'h7);
    rdy = 3'h7;
    rd(8'h0C, 32'h0);
    wr(8'h10, 32'h70);
    bus.ev(4'h8);
    s = pick(rdy);
    @(negedge ref_clk);
    chk({30'h0, tx_sel}, {30'h0, s});
    chk({31'h0, ack_enable}, 32'h0);
    chk({31'h0, tx_irq}, 32'h0);
    bus.fetch(4'h1);
    @(negedge ref_clk);
    chk({24'h0, tx_byte}, {24'h0, dw[s][15:8]});
    rx_fr(8'h5A, 1'b1);
    rd(8'h04, 32'h0);
    bus.ev(4'h1);
    p[(s + 2'd1) % 3] = 8'h00;
    wr(8'h90 + 8'(32*((s + 2'd1) % 3)), 32'h0);
    bus.ev(4'h8);
    s = pick(rdy);
    @(negedge ref_clk);
    chk({30'h0, tx_sel}, {30'h0, s});
    bus.ev(4'h4);
    rdy[s] = 1'b0;
    rd(8'h0C, {29'h0, ~rdy});
    @(negedge ref_clk);
    chk({31'h0, tx_irq}, 32'h1);
    wr(8'h00, 32'h1);
    bus.ev(4'h8);
    @(negedge ref_clk);
    chk({31'h0, ack_enable}, 32'h1);
    rx_fr(8'h5A, 1'b1);
    rd(8'h04, 32'h1);
    wr(8'h04, 32'h1);
    bus.ev(4'h2);
    @(negedge ref_clk);
    chk({31'h0, tx_sel_valid}, 32'h0);
    wr(8'h00, 32'h0);
    rx_fr(8'h5A, 1'b1);
    rd(8'h04, 32'h1);
    wr(8'h10, 32'h77);
    repeat (3) @(posedge ref_clk);
    rd(8'h0C, {25'h0, rdy, 1'b0, 3'h7});
    rd(8'h10, 32'h70);
    repeat (3) @(posedge ref_clk);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
